// ---- adc_host_port.sv ----
// Parallel host port of the successive-approximation converter.
`timescale 1ns/100ps
// Functional notes
// RULE1 - Done output goes low when result ready.
// RULE2 - Read falling edge under select drives result.
// RULE3 - Internal acquisition: write rise latches and starts.
// RULE4 - External acquisition: first write rise starts conversion; the code starts acquisition on it and converts on the second.
// RULE5 - Deselected chip floats all twelve data lines.
// RULE6 - Low eight lines are bidirectional.
// RULE7 - Upper lines are outputs only.
// RULE8 - Host clocks input externally or holds static.
// RULE9 - Power bits pick power and clock mode.
// RULE10 - Bit five picks acquisition mode.
// RULE11 - Bits pick input, range and channel.
// RULE12 - Host holds write high past first tick.
// RULE13 - Reading releases the done output high.
module adc_host_port (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic conv_clk_i,
	input wire logic [7:0] result_bus_i,
	output logic [11:0] result_bus_o,
	output logic [11:0] result_bus_oe_n_o,
	output logic done_n_o,
	input wire logic [11:0] sample_i,
	output logic track_o,
	output logic [1:0] power_clock_select_o,
	output logic acquisition_mode_select_o,
	output logic input_config_select_o,
	output logic range_polarity_select_o,
	output logic [2:0] channel_select_o
);
	// Complete state of the port.
	typedef struct packed {
		adc_port_pkg::seq_state_t state;
		logic [7:0] ctrl;
		logic ext_clk_mode;
		logic rd_n_d;
		logic wr_n_d;
		logic cclk_d;
		logic [7:0] osc_cnt;
		logic [7:0] tick_cnt;
		logic result_valid;
		logic done_n;
		logic driving;
		logic [11:0] dout;
		logic track;
		logic conv_start;
	} port_state_t;

	port_state_t st_r;
	port_state_t st_nxt;
	logic tick;
	logic rd_fall;
	logic wr_rise;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [11:0] buf_out_data;
	logic buf_pop;
	logic conv_done;

	// Decodes whether a power code keeps the chip running.
	function automatic logic is_normal(input logic [1:0] code);
		return code[1];
	endfunction

	// Edges of host strobes, seen only while the chip is selected.
	assign rd_fall = !cs_n_i && st_r.rd_n_d && !rd_n_i; // RULE2
	assign wr_rise = !cs_n_i && !st_r.wr_n_d && wr_n_i; // RULE3 RULE4
	// Conversion tick: falling edge of the external clock, or internal oscillator wrap.
	assign tick = st_r.ext_clk_mode ? (st_r.cclk_d && !conv_clk_i) : // RULE8
		(st_r.osc_cnt == 8'(adc_port_pkg::OSC_DIV - 1));
	assign conv_done = (st_r.state == adc_port_pkg::ST_CONV) && tick &&
		(st_r.tick_cnt == 8'(adc_port_pkg::CONV_TICKS - 1));
	// A new result is dropped from the buffer once the host begins reading it.
	assign buf_pop = rd_fall && buf_out_valid;

	// Results are buffered so that a slow host can leave two unread; a third is dropped while both are waiting.
	result_buffer #(
		.WIDTH(adc_port_pkg::RESULT_W)
	) u_result_buffer (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(conv_done),
		.in_ready_o(buf_in_ready),
		.in_data_i(sample_i),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_pop),
		.out_data_o(buf_out_data)
	);

	// Next-state logic for strobes, sequencer and data drive.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rd_n_d = rd_n_i;
		st_nxt.wr_n_d = wr_n_i;
		st_nxt.cclk_d = conv_clk_i;
		st_nxt.conv_start = 1'b0;
		// In internal clock mode the free-running oscillator counter wraps every period; in external mode only past 8'hff.
		if (tick && !st_r.ext_clk_mode)
		begin
			st_nxt.osc_cnt = 8'h00;
		end
		else
		begin
			st_nxt.osc_cnt = st_r.osc_cnt + 8'h01;
		end
		unique case (st_r.state)
			adc_port_pkg::ST_IDLE:
			begin
				if (wr_rise)
				begin
					// Only the low eight lines are sampled; upper lines are never inputs.
					st_nxt.ctrl = result_bus_i; // RULE6 RULE7
					// Power-down codes leave clock mode as it was.
					if (is_normal(result_bus_i[adc_port_pkg::POWER_HI:adc_port_pkg::POWER_LO])) // RULE9
					begin
						st_nxt.ext_clk_mode = result_bus_i[adc_port_pkg::POWER_LO];
						st_nxt.tick_cnt = 8'h00;
						// Bit five decides whether acquisition ends on the next write or after a fixed tick count.
						if (result_bus_i[adc_port_pkg::ACQ_BIT]) // RULE10
						begin
							st_nxt.state = adc_port_pkg::ST_ACQ;
							st_nxt.track = 1'b1;
						end
						else
						begin
							st_nxt.state = adc_port_pkg::ST_ACQ;
							st_nxt.track = 1'b1;
							st_nxt.conv_start = 1'b1; // RULE3
						end
					end
				end
			end
			adc_port_pkg::ST_ACQ:
			begin
				// External mode: the next write rise ends acquisition.
				if (st_r.ctrl[adc_port_pkg::ACQ_BIT] && wr_rise) // RULE4
				begin
					st_nxt.state = adc_port_pkg::ST_CONV;
					st_nxt.track = 1'b0;
					st_nxt.tick_cnt = 8'h00;
				end
				// Internal mode: a fixed number of ticks of acquisition.
				else if (!st_r.ctrl[adc_port_pkg::ACQ_BIT] && tick) // RULE12
				begin
					if (st_r.tick_cnt == 8'(adc_port_pkg::ACQ_TICKS - 1))
					begin
						st_nxt.state = adc_port_pkg::ST_CONV;
						st_nxt.track = 1'b0;
						st_nxt.tick_cnt = 8'h00;
					end
					else
					begin
						st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
					end
				end
			end
			adc_port_pkg::ST_CONV:
			begin
				if (tick)
				begin
					st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
				end
				if (conv_done)
				begin
					st_nxt.state = adc_port_pkg::ST_IDLE;
				end
			end
			default:
			begin
				st_nxt.state = adc_port_pkg::ST_IDLE;
			end
		endcase
		// Done goes low whenever a result waits; a read start releases it.
		st_nxt.done_n = !(buf_out_valid && !buf_pop) && !conv_done; // RULE1 RULE13
		// Drive starts on a selected read fall and ends on read rise or deselect.
		if (cs_n_i)
		begin
			st_nxt.driving = 1'b0; // RULE5
		end
		else if (rd_fall)
		begin
			st_nxt.driving = 1'b1; // RULE2
			st_nxt.dout = buf_out_data;
		end
		else if (rd_n_i)
		begin
			st_nxt.driving = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
			st_r.ctrl <= adc_port_pkg::CTRL_RESET;
			st_r.rd_n_d <= 1'b1;
			st_r.wr_n_d <= 1'b1;
			st_r.done_n <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state flops.
	assign result_bus_o = st_r.dout;
	assign result_bus_oe_n_o = {12{!st_r.driving}}; // RULE5
	assign done_n_o = st_r.done_n;
	assign track_o = st_r.track;
	assign power_clock_select_o = st_r.ctrl[adc_port_pkg::POWER_HI:adc_port_pkg::POWER_LO]; // RULE9
	assign acquisition_mode_select_o = st_r.ctrl[adc_port_pkg::ACQ_BIT]; // RULE10
	assign input_config_select_o = st_r.ctrl[adc_port_pkg::INPUT_BIT]; // RULE11
	assign range_polarity_select_o = st_r.ctrl[adc_port_pkg::RANGE_BIT]; // RULE11
	assign channel_select_o = st_r.ctrl[adc_port_pkg::CHAN_HI:adc_port_pkg::CHAN_LO]; // RULE11

	// Deselect floats the bus one cycle later.
	property p_float_on_deselect;
		@(posedge mclk_i) disable iff (sys_rst_i) cs_n_i |=> result_bus_oe_n_o == 12'hfff;
	endproperty
	a_float_on_deselect: assert property (p_float_on_deselect) else $error("bus driven while deselected"); // RULE5

	// A selected read fall drives the bus next cycle.
	property p_read_drives;
		@(posedge mclk_i) disable iff (sys_rst_i) rd_fall |=> result_bus_oe_n_o == 12'h000;
	endproperty
	a_read_drives: assert property (p_read_drives) else $error("read did not drive bus"); // RULE2

	// Internal-mode write latches the byte and enters acquisition.
	property p_int_write;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r.state == adc_port_pkg::ST_IDLE && wr_rise && result_bus_i[7] && !result_bus_i[5])
		|=> (st_r.state == adc_port_pkg::ST_ACQ) && track_o && channel_select_o == $past(result_bus_i[2:0]);
	endproperty
	a_int_write: assert property (p_int_write) else $error("internal write did not start"); // RULE3

	// External-mode write during acquisition starts conversion.
	property p_ext_write;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r.state == adc_port_pkg::ST_ACQ && st_r.ctrl[5] && wr_rise) |=> st_r.state == adc_port_pkg::ST_CONV && !track_o;
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("external write did not convert"); // RULE4

	// Finished conversion lowers done next cycle.
	property p_done_low;
		@(posedge mclk_i) disable iff (sys_rst_i) conv_done |=> !done_n_o;
	endproperty
	a_done_low: assert property (p_done_low) else $error("done not asserted"); // RULE1

	// A read start releases done unless a conversion finishes in that cycle.
	property p_done_release;
		@(posedge mclk_i) disable iff (sys_rst_i) (rd_fall && !conv_done) |=> done_n_o;
	endproperty
	a_done_release: assert property (p_done_release) else $error("done not released"); // RULE13

	// Power-down codes keep the clock mode.
	property p_pd_keeps_clk;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r.state == adc_port_pkg::ST_IDLE && wr_rise && !result_bus_i[7]) |=> $stable(st_r.ext_clk_mode);
	endproperty
	a_pd_keeps_clk: assert property (p_pd_keeps_clk) else $error("power-down changed clock mode"); // RULE9

	// External acquisition holds track until a write.
	property p_ext_hold;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r.state == adc_port_pkg::ST_ACQ && st_r.ctrl[5] && !wr_rise) |=> st_r.state == adc_port_pkg::ST_ACQ;
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("external acquisition ended early"); // RULE10

	c_conv: cover property (@(posedge mclk_i) conv_done);
	c_read: cover property (@(posedge mclk_i) rd_fall && buf_out_valid);
	c_ext: cover property (@(posedge mclk_i) st_r.state == adc_port_pkg::ST_ACQ && st_r.ctrl[5] && wr_rise);
	// Both buffer entries in use: a slow host is holding two results.
	c_full: cover property (@(posedge mclk_i) buf_out_valid && !buf_in_ready);
endmodule

// ---- adc_host_port_tb.sv ----
// Self-checking testbench for the converter's parallel host port.
`timescale 1ns/100ps
module adc_host_port_tb;
	// Clock, reset and the wires between host model and port.
	logic mclk_i;
	logic sys_rst_i;
	logic [11:0] sample_i;
	// Word and enables of a read made outside read_check.
	logic [11:0] rd_data, rd_oe_n;
	logic cs_n, rd_n, wr_n, conv_clk, done_n, track, acq, inp, rng;
	logic [11:0] bus, rbus, oe_n;
	logic [1:0] pwr;
	logic [2:0] chan;
	logic [11:0] ctrl;
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	assign ctrl = {4'h0, pwr, acq, inp, rng, chan};
	always #10 mclk_i = ~mclk_i;
	host_model host_model_i (.mclk_i(mclk_i), .dev_data_i(rbus), .dev_oe_n_i(oe_n), .cs_n_o(cs_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .conv_clk_o(conv_clk), .bus_o(bus));
	adc_host_port adc_host_port_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.conv_clk_i(conv_clk), .result_bus_i(bus[7:0]), .result_bus_o(rbus), .result_bus_oe_n_o(oe_n),
		.done_n_o(done_n), .sample_i(sample_i), .track_o(track), .power_clock_select_o(pwr),
		.acquisition_mode_select_o(acq), .input_config_select_o(inp), .range_polarity_select_o(rng),
		.channel_select_o(chan));
	// One comparison, counted and reported at once.
	task automatic check(input logic [11:0] exp, input logic [11:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
			n_fail++;
		end
	endtask
	// Waits a bounded time for the done flag; a miss shows up in the caller's next check.
	task automatic wait_done;
		int k;
		k = 0;
		while (done_n !== 1'b0 && k < 600)
		begin
			@(negedge mclk_i);
			k++;
		end
	endtask
	// Waits for the done flag, then reads and checks the word.
	task automatic read_check(input logic [11:0] exp);
		logic [11:0] d, e;
		wait_done();
		check(12'h000, {11'h0, done_n});
		host_model_i.read_word(d, e);
		check(exp, d);
		check(12'h000, e);
		check(12'h001, {11'h0, done_n});
		repeat (2) @(negedge mclk_i);
		check(12'hfff, oe_n);
	endtask
	// Verdict, printed in one place only.
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A hang counts as a failure; the whole run needs under 2500 cycles.
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			complete_run();
		end
	end
	initial
	begin
		mclk_i = 1'b0;
		sys_rst_i = 1'b1;
		sample_i = 12'ha5c;
		repeat (5) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		check(12'hfff, oe_n);
		check(12'h080, ctrl);
		check(12'h001, {11'h0, done_n});
		$display("test reset done");
		host_model_i.write_byte(8'h9b);
		check(12'h09b, ctrl);
		check(12'h001, {11'h0, track});
		read_check(12'ha5c);
		$display("test internal acquisition done");
		sample_i = 12'h3c1;
		host_model_i.write_byte(8'ha0);
		repeat (60) @(negedge mclk_i);
		check(12'h001, {11'h0, track});
		host_model_i.write_byte(8'ha0);
		check(12'h000, {11'h0, track});
		read_check(12'h3c1);
		$display("test external acquisition done");
		sample_i = 12'h5a3;
		host_model_i.ext_clk_r = 1'b1;
		host_model_i.write_byte(8'hc7);
		check(12'h0c7, ctrl);
		read_check(12'h5a3);
		host_model_i.ext_clk_r = 1'b0;
		$display("test external clock done");
		host_model_i.write_byte(8'h1f);
		check(12'h01f, ctrl);
		host_model_i.write_byte(8'h5e);
		check(12'h05e, ctrl);
		repeat (250) @(negedge mclk_i);
		check(12'h000, {11'h0, track});
		check(12'h001, {11'h0, done_n});
		$display("test power-down codes done");
		// Two results left unread must both come back, oldest first.
		sample_i = 12'h1e7;
		host_model_i.write_byte(8'h80);
		wait_done();
		sample_i = 12'h2d4;
		host_model_i.write_byte(8'h80);
		repeat (250) @(negedge mclk_i);
		check(12'h000, {11'h0, done_n});
		host_model_i.read_word(rd_data, rd_oe_n);
		check(12'h1e7, rd_data);
		check(12'h000, rd_oe_n);
		read_check(12'h2d4);
		$display("test two waiting results done");
		// Reset in mid-acquisition returns every output to its idle value.
		host_model_i.write_byte(8'ha0);
		check(12'h001, {11'h0, track});
		sys_rst_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		check(12'h000, {11'h0, track});
		check(12'h080, ctrl);
		check(12'hfff, oe_n);
		check(12'h001, {11'h0, done_n});
		// The first request after release must work at once.
		sample_i = 12'h7b2;
		host_model_i.write_byte(8'h80);
		check(12'h080, ctrl);
		read_check(12'h7b2);
		$display("test mid-run reset done");
		complete_run();
	end
endmodule

// ---- adc_port_pkg.sv ----
// Package with constants for the parallel host port of the 12-bit converter.
package adc_port_pkg;
	// Result and control widths.
	localparam int RESULT_W = 12;
	localparam int CTRL_W = 8;
	// Control byte field positions.
	localparam int POWER_HI = 7;
	localparam int POWER_LO = 6;
	localparam int ACQ_BIT = 5;
	localparam int INPUT_BIT = 4;
	localparam int RANGE_BIT = 3;
	localparam int CHAN_HI = 2;
	localparam int CHAN_LO = 0;
	// Power codes.
	localparam logic [1:0] PWR_DOWN = 2'h0;
	localparam logic [1:0] PWR_STANDBY = 2'h1;
	localparam logic [1:0] PWR_NORM_INT = 2'h2;
	localparam logic [1:0] PWR_NORM_EXT = 2'h3;
	// Reset value of the control byte: normal operation, internal clock and acquisition.
	localparam logic [7:0] CTRL_RESET = 8'h80;
	// Acquisition time and conversion length in conversion clock ticks.
	localparam int ACQ_TICKS = 3;
	localparam int CONV_TICKS = 13;
	// Internal oscillator period in ns and the derived system clock count.
	localparam int MCLK_PERIOD_NS = 20;
	localparam int OSC_PERIOD_NS = 220;
	localparam int OSC_DIV = OSC_PERIOD_NS / MCLK_PERIOD_NS;
	localparam int CNT_W = 8;
	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ = 2'b01,
		ST_CONV = 2'b10
	} seq_state_t;
endpackage

// ---- host_model.sv ----
// Host processor model that drives the converter's strobes, low data lines and conversion clock.
`timescale 1ns/100ps
module host_model (
	input wire logic mclk_i,
	input wire logic [11:0] dev_data_i,
	input wire logic [11:0] dev_oe_n_i,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic conv_clk_o,
	output logic [11:0] bus_o
);
	// Host drive of the low lines and whether it is on.
	logic [7:0] drv_r = 8'h00;
	logic drv_en_r = 1'b0;
	// Last wire level; a released line shows its inverse, so stale data never passes as fresh.
	logic [11:0] last_r = 12'h000;
	// Set by the bench to run the external conversion clock.
	logic ext_clk_r = 1'b0;
	initial
	begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		conv_clk_o = 1'b1;
	end
	// Per-bit wire level: the device wins where enabled, else the host, else the floating pattern.
	assign bus_o = (~dev_oe_n_i & dev_data_i) | (dev_oe_n_i & (drv_en_r ? {~last_r[11:8], drv_r} : ~last_r));
	always @(posedge mclk_i) last_r <= bus_o;
	// A 240 ns clock only when asked for; otherwise it is held high.
	always #120 conv_clk_o = ext_clk_r ? ~conv_clk_o : 1'b1;
	// One control byte write; the strobe stays high afterwards past the first conversion tick.
	task automatic write_byte(input logic [7:0] b);
		@(negedge mclk_i);
		cs_n_o = 1'b0;
		drv_r = b;
		drv_en_r = 1'b1;
		wr_n_o = 1'b0;
		repeat (3) @(negedge mclk_i);
		wr_n_o = 1'b1;
		repeat (2) @(negedge mclk_i);
		cs_n_o = 1'b1;
		drv_en_r = 1'b0;
	endtask
	// One result read; data and enables are taken two cycles after rd_n falls.
	task automatic read_word(output logic [11:0] d, output logic [11:0] oe_n);
		@(negedge mclk_i);
		cs_n_o = 1'b0;
		@(negedge mclk_i);
		rd_n_o = 1'b0;
		repeat (2) @(negedge mclk_i);
		d = bus_o;
		oe_n = dev_oe_n_i;
		rd_n_o = 1'b1;
		@(negedge mclk_i);
		cs_n_o = 1'b1;
	endtask
endmodule

// ---- result_buffer.sv ----
// Two-entry valid/ready buffer holding conversion results.
`timescale 1ns/100ps
module result_buffer #(
	parameter int WIDTH = 12
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	// Whole buffer state.
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} buf_state_t;

	buf_state_t st_r;
	buf_state_t st_nxt;
	logic push;
	logic pop;

	// Handshakes on both sides; the buffer refuses a push when full.
	assign push = in_valid_i && (st_r.count != 2'h2);
	assign pop = out_ready_i && (st_r.count != 2'h0);
	assign in_ready_o = (st_r.count != 2'h2);
	assign out_valid_o = (st_r.count != 2'h0);
	assign out_data_o = st_r.mem[st_r.rd_ptr];

	// Next-state computation for pointers, count and storage.
	always_comb
	begin
		st_nxt = st_r;
		if (push)
		begin
			st_nxt.mem[st_r.wr_ptr] = in_data_i;
			st_nxt.wr_ptr = ~st_r.wr_ptr;
		end
		if (pop)
		begin
			st_nxt.rd_ptr = ~st_r.rd_ptr;
		end
		st_nxt.count = st_r.count + {1'b0, push} - {1'b0, pop};
	end

	// State register.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end
endmodule
